// ---- logic/led_dimming_pwm_defs.svh ----
// Constants for the LED dimming PWM control block
`ifndef LED_DIMMING_PWM_DEFS_SVH
`define LED_DIMMING_PWM_DEFS_SVH

// Clock rates in ns and the 20 MHz dimming step derived from them
`define LDP_CORE_PERIOD_NS 5
`define LDP_OSC_PERIOD_NS 50
`define LDP_TICK_DIV (`LDP_OSC_PERIOD_NS / `LDP_CORE_PERIOD_NS)

// Default linear sloper duration
`define LDP_SLOPE_DEFAULT_MS 200
`define LDP_SLOPE_DEFAULT_CYCLES (`LDP_SLOPE_DEFAULT_MS * 1000000 / `LDP_CORE_PERIOD_NS)
`define LDP_SLOPE_DEFAULT_SEL 3'h4
`define LDP_SLOPE_STEPS_LOG2 8

// Input duty measurement window in 20 MHz ticks
`define LDP_DUTY_WINDOW_TICKS 65536

// Last strap settle count after leaving shutdown; the settle state lasts 4 core cycles
`define LDP_STRAP_SETTLE 2'h3

// Dimming period of the slowest frequency code, as a counter mask
`define LDP_PERIOD_MASK_MAX 17'h1_FFFF

// Brightness and current scale figures
`define LDP_BRT_FULL 16'hFFFF
`define LDP_BRT_ZERO 16'h0000
`define LDP_HYBRID_KNEE 16'h2000
`define LDP_HYBRID_CUR 16'h1FFF
`define LDP_SCALE_FULL 12'hFFF

// String configuration codes
`define LDP_CFG_PAIRS 3'h5
`define LDP_CFG_TRIPLES 3'h6
`define LDP_CFG_SINGLE 3'h7

// Target addresses chosen by the upper bit of the mode strap
`define LDP_ADDR_LOWER 7'h2B
`define LDP_ADDR_UPPER 7'h2A

`endif

// ---- logic/led_dimming_pwm_pkg.sv ----
// Types shared by the LED dimming PWM control block
package led_dimming_pwm_pkg;

  // Dimming mode selected by the low bits of the mode strap
  typedef enum logic [1:0] {
    MODE_PHASE_PWM = 2'h0,
    MODE_HYBRID = 2'h1,
    MODE_CURRENT = 2'h2,
    MODE_DIRECT = 2'h3
  } dim_mode_e;

  // Strap capture sequence
  typedef enum logic [2:0] {
    ST_SHUTDOWN = 3'b001,
    ST_SETTLE = 3'b010,
    ST_RUN = 3'b100
  } strap_state_e;

  // Drive toward the six current sinks
  typedef struct packed {
    logic [5:0] sinkOn;
    logic [5:0][11:0] sinkCurrent;
  } sink_drive_s;

  // Captured strap settings
  typedef struct packed {
    logic [2:0] freqSel;
    logic [2:0] stringConfig;
    dim_mode_e mode;
    logic addrUpper;
  } strap_set_s;

endpackage : led_dimming_pwm_pkg

// ---- logic/pwm_channel_slot.sv ----
// One sink channel: phase-shifted PWM compare or direct follow of the input
`timescale 1ns/100ps
`include "led_dimming_pwm_defs.svh"

module pwm_channel_slot (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic active,
  input wire logic direct,
  input wire logic pinLevel,
  input wire logic [16:0] periodCnt,
  input wire logic [16:0] periodMask,
  input wire logic [16:0] phaseOffset,
  input wire logic [17:0] dutyTicks,
  output logic sinkOn
);

  // Position within this channel's own shifted period
  logic [16:0] localCnt;
  logic onNext;

  assign localCnt = (periodCnt - phaseOffset) & periodMask;
  // Direct mode follows the input edges; otherwise the shifted compare
  assign onNext = run && active && (direct ? pinLevel : ({1'b0, localCnt} < dutyTicks));

  // Registered so every sink edge lines up with the core clock
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sinkOn <= 1'b0;
    end else begin
      sinkOn <= onNext;
    end
  end

endmodule : pwm_channel_slot

// ---- logic/led_dimming_pwm_control.sv ----
// Dimming control for a six-channel LED current-sink driver
`timescale 1ns/100ps
`include "led_dimming_pwm_defs.svh"

// Function
// - Each string has a 12-bit scale; current is scale/4095 of maximum, resets full.
// - Ungrouped strings get 60, 72, 90, 120 or 180 degree spacing by count.
// - Pairs, triples or one gang get 120, 180 or no offset between groups.
// - Configuration strap sampled at power-up; may change only during shutdown.
// - LED PWM comes from the 20 MHz oscillator, eight frequencies, not input timing.
// - Frequency strap picks 152 Hz to 19531 Hz, resolution 16 down to 10 bits.
// - Dimming frequency is independent of input only in phase-shift and hybrid modes.
// - One global brightness for all strings, from input duty or written register.
// - Source select chooses pin or register; pin is the default after power-on.
// - Brightness path has a sloper enabled after reset; settings are changeable.
// - Mode strap picks four modes; low codes give address 0x2B, high 0x2A.
// - Phase-shift mode switches all active channels at dimming rate with fixed delay.
// - Hybrid mode uses PWM at low brightness and current dimming at high.
// - Hybrid knee selectable at 12.5% or 0%; 0% gives pure current dimming.
// - Direct mode switches all active channels with the input PWM edges.
// - Sloper defaults to 200 ms linear transitions; select 000 disables it.
module led_dimming_pwm_control #(
  parameter int SLOPE_BASE_CYCLES = `LDP_SLOPE_DEFAULT_CYCLES,
  parameter int DUTY_WINDOW_TICKS = `LDP_DUTY_WINDOW_TICKS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic shutdown,
  input wire logic pwmPin,
  input wire logic [2:0] dimmingFreqStrap,
  input wire logic [2:0] stringConfigStrap,
  input wire logic [2:0] modeStrap,
  input wire logic brightnessSourceSelect,
  input wire logic [15:0] displayBrightnessValue,
  input wire logic [5:0][11:0] stringCurrentScale,
  input wire logic [2:0] slopeSelect,
  input wire logic hybridZeroKnee,
  output led_dimming_pwm_pkg::sink_drive_s sinkDrive,
  output logic [6:0] targetAddress,
  output logic strapsValid,
  output logic [15:0] brightnessNow
);

  localparam int TICK_DIV = `LDP_TICK_DIV;
  localparam int SLOPE_INTERVAL = SLOPE_BASE_CYCLES >> `LDP_SLOPE_STEPS_LOG2;

  // Pin synchroniser; the first stage feeds only the second
  logic pinSync1Reg;
  logic pinSync2Reg;
  logic pinSync3Reg;
  logic pinLevelReg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pinSync1Reg <= 1'b0;
      pinSync2Reg <= 1'b0;
      pinSync3Reg <= 1'b0;
      pinLevelReg <= 1'b0;
    end else begin
      pinSync1Reg <= pwmPin;
      pinSync2Reg <= pinSync1Reg;
      pinSync3Reg <= pinSync2Reg;
      if (pinSync2Reg == pinSync3Reg) begin
        pinLevelReg <= pinSync3Reg;
      end
    end
  end

  // 20 MHz dimming step as a one-cycle enable from the core clock
  logic [3:0] tickCntReg;
  logic tick;

  assign tick = (tickCntReg == 4'(TICK_DIV - 1));

  always_ff @(posedge core_clk) begin
    if (!rst_n || tick) begin
      tickCntReg <= 4'h0;
    end else begin
      tickCntReg <= tickCntReg + 4'h1;
    end
  end

  // Strap capture: straps are taken once per exit from shutdown and then frozen
  led_dimming_pwm_pkg::strap_state_e stateReg;
  led_dimming_pwm_pkg::strap_state_e stateNext;
  led_dimming_pwm_pkg::strap_set_s strapReg;
  logic [1:0] settleReg;
  logic run;

  assign run = (stateReg == led_dimming_pwm_pkg::ST_RUN);

  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      led_dimming_pwm_pkg::ST_SHUTDOWN: begin
        if (!shutdown) stateNext = led_dimming_pwm_pkg::ST_SETTLE;
      end
      led_dimming_pwm_pkg::ST_SETTLE: begin
        if (shutdown) stateNext = led_dimming_pwm_pkg::ST_SHUTDOWN;
        else if (settleReg == `LDP_STRAP_SETTLE) stateNext = led_dimming_pwm_pkg::ST_RUN;
      end
      led_dimming_pwm_pkg::ST_RUN: begin
        if (shutdown) stateNext = led_dimming_pwm_pkg::ST_SHUTDOWN;
      end
      default: stateNext = led_dimming_pwm_pkg::ST_SHUTDOWN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stateReg <= led_dimming_pwm_pkg::ST_SHUTDOWN;
      settleReg <= 2'h0;
      strapReg <= '0;
    end else begin
      stateReg <= stateNext;
      settleReg <= (stateReg == led_dimming_pwm_pkg::ST_SETTLE) ? settleReg + 2'h1 : 2'h0;
      if (stateReg == led_dimming_pwm_pkg::ST_SETTLE && stateNext == led_dimming_pwm_pkg::ST_RUN) begin
        strapReg.freqSel <= dimmingFreqStrap;
        strapReg.stringConfig <= stringConfigStrap;
        strapReg.mode <= led_dimming_pwm_pkg::dim_mode_e'(modeStrap[1:0]);
        strapReg.addrUpper <= modeStrap[2];
      end
    end
  end

  assign strapsValid = run;
  assign targetAddress = strapReg.addrUpper ? `LDP_ADDR_UPPER : `LDP_ADDR_LOWER;

  // Dimming period: each frequency code halves the slowest period
  logic [16:0] periodMask;
  logic [16:0] periodCntReg;

  assign periodMask = `LDP_PERIOD_MASK_MAX >> strapReg.freqSel;

  // Free-running on the oscillator step, never on the input pin
  always_ff @(posedge core_clk) begin
    if (!rst_n || !run) begin
      periodCntReg <= 17'h0_0000;
    end else if (tick) begin
      periodCntReg <= (periodCntReg + 17'h0_0001) & periodMask;
    end
  end

  // Input duty: fraction of high ticks over a fixed window, blind to input frequency
  logic [16:0] windowCntReg;
  logic [16:0] highCntReg;
  logic [15:0] pinDutyReg;
  logic windowEnd;
  logic [16:0] highNext;
  logic [32:0] dutyScaled;

  assign windowEnd = tick && (windowCntReg == 17'(DUTY_WINDOW_TICKS - 1));
  // The closing tick counts too, and the count is scaled so any window length reads full scale
  assign highNext = highCntReg + {16'h0000, pinLevelReg};
  assign dutyScaled = {highNext, 16'h0000} / 33'(DUTY_WINDOW_TICKS);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      windowCntReg <= 17'h0_0000;
      highCntReg <= 17'h0_0000;
      pinDutyReg <= `LDP_BRT_ZERO;
    end else if (windowEnd) begin
      windowCntReg <= 17'h0_0000;
      highCntReg <= 17'h0_0000;
      pinDutyReg <= (dutyScaled[32:16] != 17'h0_0000) ? `LDP_BRT_FULL : dutyScaled[15:0];
    end else if (tick) begin
      windowCntReg <= windowCntReg + 17'h0_0001;
      highCntReg <= highNext;
    end
  end

  // One global target, pin duty when the select is low
  logic [15:0] targetBrt;

  assign targetBrt = brightnessSourceSelect ? displayBrightnessValue : pinDutyReg;

  // Linear sloper: each step is the gap over 256, at least 1, so only large changes take about the set time
  logic [15:0] curBrtReg;
  logic [15:0] lastTargetReg;
  logic [15:0] stepReg;
  logic [31:0] slopeCntReg;
  logic [31:0] slopeInterval;
  logic [15:0] gap;
  logic slopeStep;
  logic [15:0] upSum;

  // Select 4 gives the base duration; each code above or below doubles or halves it
  assign slopeInterval = (slopeSelect >= `LDP_SLOPE_DEFAULT_SEL)
    ? 32'(SLOPE_INTERVAL) << (slopeSelect - `LDP_SLOPE_DEFAULT_SEL)
    : 32'(SLOPE_INTERVAL) >> (`LDP_SLOPE_DEFAULT_SEL - slopeSelect);
  assign gap = (targetBrt > curBrtReg) ? targetBrt - curBrtReg : curBrtReg - targetBrt;
  assign slopeStep = (slopeCntReg + 32'h0000_0001 >= slopeInterval);
  assign upSum = (16'hFFFF - curBrtReg > stepReg) ? curBrtReg + stepReg : `LDP_BRT_FULL;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      curBrtReg <= `LDP_BRT_ZERO;
      lastTargetReg <= `LDP_BRT_ZERO;
      stepReg <= 16'h0001;
      slopeCntReg <= 32'h0000_0000;
    end else if (slopeSelect == 3'h0) begin
      curBrtReg <= targetBrt;
      lastTargetReg <= targetBrt;
      slopeCntReg <= 32'h0000_0000;
    end else if (targetBrt != lastTargetReg) begin
      // New target: fix the step now so the ramp stays linear
      lastTargetReg <= targetBrt;
      stepReg <= (gap[15:8] == 8'h00) ? 16'h0001 : {8'h00, gap[15:8]};
      slopeCntReg <= 32'h0000_0000;
    end else if (slopeStep) begin
      slopeCntReg <= 32'h0000_0000;
      if (gap <= stepReg) curBrtReg <= targetBrt;
      else if (targetBrt > curBrtReg) curBrtReg <= upSum;
      else curBrtReg <= curBrtReg - stepReg;
    end else begin
      slopeCntReg <= slopeCntReg + 32'h0000_0001;
    end
  end

  assign brightnessNow = curBrtReg;

  // Split brightness into a PWM share and an amplitude share by mode
  logic hybridLow;
  logic [15:0] pwmBrt;
  logic [15:0] ampBrt;
  logic direct;

  assign hybridLow = !hybridZeroKnee && (curBrtReg < `LDP_HYBRID_KNEE);
  assign direct = (strapReg.mode == led_dimming_pwm_pkg::MODE_DIRECT);

  always_comb begin
    pwmBrt = `LDP_BRT_FULL;
    ampBrt = `LDP_BRT_FULL;
    case (strapReg.mode)
      led_dimming_pwm_pkg::MODE_PHASE_PWM: pwmBrt = curBrtReg;
      led_dimming_pwm_pkg::MODE_HYBRID: begin
        if (hybridLow) begin
          pwmBrt = {curBrtReg[12:0], 3'h0};
          ampBrt = `LDP_HYBRID_CUR;
        end else begin
          ampBrt = curBrtReg;
        end
      end
      led_dimming_pwm_pkg::MODE_CURRENT: ampBrt = curBrtReg;
      default: begin
        pwmBrt = `LDP_BRT_FULL;
        ampBrt = `LDP_BRT_FULL;
      end
    endcase
  end

  // Duty in ticks; full scale holds the sink on through the whole period
  logic [17:0] dutyTicks;

  assign dutyTicks = (pwmBrt == `LDP_BRT_FULL) ? {1'b0, periodMask} + 18'h0_0001
    : 18'({pwmBrt, 1'b0} >> strapReg.freqSel);

  // Group count and per-channel group from the captured string configuration
  logic [2:0] groupCount;

  assign groupCount = (strapReg.stringConfig == `LDP_CFG_PAIRS) ? 3'h3
    : (strapReg.stringConfig == `LDP_CFG_TRIPLES) ? 3'h2
    : (strapReg.stringConfig == `LDP_CFG_SINGLE) ? 3'h1
    : 3'(3'h6 - strapReg.stringConfig);

  // Per-channel results gathered here so the output struct has one driver
  logic [5:0] sinkOnAll;
  logic [5:0][11:0] sinkCurrentAll;

  assign sinkDrive = {sinkOnAll, sinkCurrentAll};

  genvar ch;
  generate
    for (ch = 0; ch < 6; ch++) begin : g_chan
      logic [2:0] group;
      logic active;
      logic [20:0] phaseProd;
      logic [16:0] phaseOffset;
      logic [27:0] ampProd;
      logic [11:0] currentReg;

      assign group = (strapReg.stringConfig == `LDP_CFG_PAIRS) ? 3'(ch / 2)
        : (strapReg.stringConfig == `LDP_CFG_TRIPLES) ? 3'(ch / 3)
        : (strapReg.stringConfig == `LDP_CFG_SINGLE) ? 3'h0
        : 3'(ch);
      assign active = (group < groupCount);
      // Offset is group times the period over the group count
      assign phaseProd = ({4'h0, periodMask} + 21'h00_0001) * {18'h0_0000, group};
      assign phaseOffset = 17'(phaseProd / {18'h0_0000, groupCount});
      // Amplitude is the string's own scale times the global amplitude share
      assign ampProd = stringCurrentScale[ch] * ampBrt;

      always_ff @(posedge core_clk) begin
        if (!rst_n || !run) begin
          currentReg <= 12'h000;
        end else begin
          currentReg <= active ? ampProd[27:16] + 12'(ampProd[15]) : 12'h000;
        end
      end

      assign sinkCurrentAll[ch] = currentReg;

      pwm_channel_slot u_slot (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(run),
        .active(active),
        .direct(direct),
        .pinLevel(pinLevelReg),
        .periodCnt(periodCntReg),
        .periodMask(periodMask),
        .phaseOffset(phaseOffset),
        .dutyTicks(dutyTicks),
        .sinkOn(sinkOnAll[ch])
      );
    end
  endgenerate

endmodule : led_dimming_pwm_control

// ---- testbench/led_dimming_pwm_control_props.sv ----
// Port-level checks for the LED dimming control block
`timescale 1ns/100ps
module led_dimming_pwm_control_props #(
  parameter int SLOPE_BASE_CYCLES = 2560,
  parameter int DUTY_WINDOW_TICKS = 256
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic shutdown,
  input wire logic pwmPin,
  input wire logic [2:0] dimmingFreqStrap,
  input wire logic [2:0] stringConfigStrap,
  input wire logic [2:0] modeStrap,
  input wire logic brightnessSourceSelect,
  input wire logic [15:0] displayBrightnessValue,
  input wire logic [5:0][11:0] stringCurrentScale,
  input wire logic [2:0] slopeSelect,
  input wire logic hybridZeroKnee,
  input wire led_dimming_pwm_pkg::sink_drive_s sinkDrive,
  input wire logic [6:0] targetAddress,
  input wire logic strapsValid,
  input wire logic [15:0] brightnessNow
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Reset itself must clear the outputs, so that check ignores the default disable
  a_reset_clears:
    assert property (disable iff (1'b0) !rst_n |=> sinkDrive == '0 && !strapsValid && brightnessNow == 16'h0000)
    else $error("outputs not cleared by reset");
  a_shutdown_dark:
    assert property (shutdown [*3] |-> sinkDrive.sinkOn == 6'h00 && !strapsValid)
    else $error("sinks on during shutdown");
  a_addr_from_strap:
    assert property ($rose(strapsValid) |-> targetAddress == (modeStrap[2] ? 7'h2A : 7'h2B))
    else $error("address does not follow mode strap");
  a_addr_held:
    assert property (strapsValid && $past(strapsValid) |-> $stable(targetAddress))
    else $error("address changed while running");
  a_unused_off:
    assert property (strapsValid && stringConfigStrap == 3'h4 |-> sinkDrive.sinkOn[5:2] == 4'h0)
    else $error("unused channel switched on");
  a_pair_match:
    assert property (strapsValid && stringConfigStrap == 3'h5
      |-> sinkDrive.sinkOn[1] == sinkDrive.sinkOn[0] && sinkDrive.sinkOn[3] == sinkDrive.sinkOn[2])
    else $error("paired channels differ");
  a_direct_follow:
    assert property ((strapsValid && modeStrap == 3'h3 && stringConfigStrap == 3'h0 && pwmPin) [*6]
      |-> sinkDrive.sinkOn == 6'h3F)
    else $error("direct mode sinks do not follow pin");
  a_full_scale:
    assert property ((strapsValid && modeStrap == 3'h0 && stringCurrentScale[0] == 12'hFFF) [*6]
      |-> sinkDrive.sinkCurrent[0] == 12'hFFF)
    else $error("full scale current wrong");
  a_slope_off:
    assert property ((strapsValid && brightnessSourceSelect && slopeSelect == 3'h0
      && $stable(displayBrightnessValue)) [*3] |-> brightnessNow == displayBrightnessValue)
    else $error("brightness not direct with sloper off");

  // Main scenarios reached
  c_capture: cover property ($rose(strapsValid));
  c_direct: cover property (modeStrap == 3'h3 && sinkDrive.sinkOn == 6'h3F);
  c_ramp: cover property (slopeSelect == 3'h4 && $changed(brightnessNow));
endmodule : led_dimming_pwm_control_props

bind led_dimming_pwm_control led_dimming_pwm_control_props #(
  .SLOPE_BASE_CYCLES(SLOPE_BASE_CYCLES), .DUTY_WINDOW_TICKS(DUTY_WINDOW_TICKS)
) props (.core_clk(core_clk), .rst_n(rst_n), .shutdown(shutdown), .pwmPin(pwmPin),
  .dimmingFreqStrap(dimmingFreqStrap), .stringConfigStrap(stringConfigStrap), .modeStrap(modeStrap),
  .brightnessSourceSelect(brightnessSourceSelect), .displayBrightnessValue(displayBrightnessValue),
  .stringCurrentScale(stringCurrentScale), .slopeSelect(slopeSelect), .hybridZeroKnee(hybridZeroKnee),
  .sinkDrive(sinkDrive), .targetAddress(targetAddress), .strapsValid(strapsValid),
  .brightnessNow(brightnessNow));

// ---- testbench/pwm_host_model.sv ----
// Host side model driving the brightness PWM pin
`timescale 1ns/100ps
module pwm_host_model (
  input wire logic core_clk,
  input wire logic [15:0] highCyc,
  input wire logic [15:0] lowCyc,
  output logic pwmPin
);
  logic [15:0] cnt;

  // Zero low time holds the pin high, zero high time holds it low; one process drives the pin
  initial begin
    pwmPin = 1'b0;
    cnt = 16'h0000;
    forever begin
      @(posedge core_clk);
      #1;
      cnt = cnt + 16'h0001;
      if (lowCyc == 16'h0000) begin
        pwmPin = 1'b1;
      end else if (highCyc == 16'h0000) begin
        pwmPin = 1'b0;
      end else if (cnt >= (pwmPin ? highCyc : lowCyc)) begin
        pwmPin = ~pwmPin;
        cnt = 16'h0000;
      end
    end
  end
endmodule : pwm_host_model

// ---- testbench/led_dimming_pwm_control_tb.sv ----
// Self-checking bench for the LED dimming control block
`timescale 1ns/100ps
module led_dimming_pwm_control_tb;
  logic core_clk, rst_n, shutdown, pwmPin, brightnessSourceSelect, hybridZeroKnee, strapsValid;
  logic [2:0] dimmingFreqStrap, stringConfigStrap, modeStrap, slopeSelect;
  logic [15:0] displayBrightnessValue, brightnessNow, hiCyc, loCyc;
  logic [5:0][11:0] stringCurrentScale;
  logic [6:0] targetAddress;
  led_dimming_pwm_pkg::sink_drive_s sinkDrive;
  int error_cnt, n_tests;
  // Entries: mode, knee, brightness, expected channel current
  logic [35:0] hyb [5] = '{36'h1_0100_0200, 36'h1_0C00_0BFF, 36'h1_1100_0100, 36'h2_0100_0100, 36'h0_0FFF_FFFF};
  // Entries: frequency code, string configuration
  logic [5:0] ph [4] = '{6'h3C, 6'h3D, 6'h34, 6'h3E};

  // Short sloper and duty window keep the run brief
  led_dimming_pwm_control #(.SLOPE_BASE_CYCLES(2560), .DUTY_WINDOW_TICKS(256)) dut (.core_clk(core_clk),
    .rst_n(rst_n), .shutdown(shutdown), .pwmPin(pwmPin), .dimmingFreqStrap(dimmingFreqStrap),
    .stringConfigStrap(stringConfigStrap), .modeStrap(modeStrap), .brightnessSourceSelect(brightnessSourceSelect),
    .displayBrightnessValue(displayBrightnessValue), .stringCurrentScale(stringCurrentScale),
    .slopeSelect(slopeSelect), .hybridZeroKnee(hybridZeroKnee), .sinkDrive(sinkDrive),
    .targetAddress(targetAddress), .strapsValid(strapsValid), .brightnessNow(brightnessNow));
  pwm_host_model host (.core_clk(core_clk), .highCyc(hiCyc), .lowCyc(loCyc), .pwmPin(pwmPin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  // Straps change only inside shutdown, after the running flag has dropped
  task automatic boot(input logic [2:0] f, input logic [2:0] c, input logic [2:0] m);
    shutdown = 1'b1;
    tick(3);
    dimmingFreqStrap = f;
    stringConfigStrap = c;
    modeStrap = m;
    tick(1);
    shutdown = 1'b0;
    for (int i = 0; i < 20 && strapsValid !== 1'b1; i++) tick(1);
    chk(strapsValid, 1'b1);
    chk(targetAddress, m[2] ? 7'h2A : 7'h2B);
    tick(3);
  endtask : boot

  // Half brightness over one period: on time, overlap and grouping
  task automatic phase(input logic [2:0] f, input logic [2:0] c);
    int per, on0, onB, both, bad, b;
    per = 10 * (131072 >> f);
    // Second channel watched: next group for pairs and triples, the other string otherwise
    b = (c == 3'h5) ? 2 : (c == 3'h6) ? 3 : 1;
    on0 = 0;
    onB = 0;
    both = 0;
    bad = 0;
    boot(f, c, 3'h0);
    tick(20);
    repeat (per) begin
      tick(1);
      on0 += (sinkDrive.sinkOn[0] === 1'b1);
      onB += (sinkDrive.sinkOn[b] === 1'b1);
      both += (sinkDrive.sinkOn[0] === 1'b1 && sinkDrive.sinkOn[b] === 1'b1);
      bad += (c == 3'h4) ? (sinkDrive.sinkOn[5:2] !== 4'h0) : (sinkDrive.sinkOn[1] !== sinkDrive.sinkOn[0]);
    end
    chk(on0, per / 2);
    chk(onB, per / 2);
    chk(both, c == 3'h5 ? per / 2 - 10 * (per / 30) : 0);
    chk(bad, 0);
  endtask : phase

  task automatic test_done();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Watchdog sized well above the expected run of about 66k cycles
  initial begin
    #(5 * 90000);
    error_cnt++;
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    shutdown = 1'b0;
    dimmingFreqStrap = 3'h7;
    stringConfigStrap = 3'h0;
    modeStrap = 3'h0;
    brightnessSourceSelect = 1'b0;
    displayBrightnessValue = 16'h0000;
    stringCurrentScale = {6{12'hFFF}};
    slopeSelect = 3'h0;
    hybridZeroKnee = 1'b0;
    hiCyc = 16'h0000;
    loCyc = 16'h0001;
    error_cnt = 0;
    n_tests = 0;
    tick(3);
    chk(sinkDrive.sinkOn, 6'h00);
    chk(targetAddress, 7'h2B);
    rst_n = 1'b1;
    boot(3'h7, 3'h0, 3'h0);
    modeStrap = 3'h4;
    tick(10);
    chk(targetAddress, 7'h2B);
    boot(3'h7, 3'h0, 3'h4);
    brightnessSourceSelect = 1'b1;
    displayBrightnessValue = 16'h8000;
    foreach (ph[i]) phase(ph[i][5:3], ph[i][2:0]);
    foreach (hyb[i]) begin
      hybridZeroKnee = hyb[i][28];
      displayBrightnessValue = hyb[i][27:12];
      boot(3'h7, 3'h0, hyb[i][34:32]);
      tick(20);
      chk(sinkDrive.sinkCurrent[0], hyb[i][11:0]);
      if (i > 0) chk(sinkDrive.sinkOn, 6'h3F);
    end
    stringCurrentScale[2] = 12'h800;
    tick(10);
    chk(sinkDrive.sinkCurrent[2], 12'h800);
    boot(3'h7, 3'h0, 3'h3);
    loCyc = 16'h0000;
    tick(10);
    chk(sinkDrive.sinkOn, 6'h3F);
    loCyc = 16'h0001;
    tick(10);
    chk(sinkDrive.sinkOn, 6'h00);
    hiCyc = 16'h001E;
    loCyc = 16'h001E;
    tick(200);
    boot(3'h7, 3'h0, 3'h0);
    brightnessSourceSelect = 1'b0;
    hiCyc = 16'h0001;
    loCyc = 16'h0000;
    tick(6000);
    chk(brightnessNow, 16'hFFFF);
    hiCyc = 16'h0000;
    loCyc = 16'h0001;
    tick(6000);
    chk(brightnessNow, 16'h0000);
    brightnessSourceSelect = 1'b1;
    displayBrightnessValue = 16'h0000;
    tick(5);
    slopeSelect = 3'h4;
    tick(2);
    displayBrightnessValue = 16'hFFFF;
    tick(40);
    chk(brightnessNow > 16'h0000 && brightnessNow < 16'hFFFF, 1'b1);
    for (int i = 0; i < 4000 && brightnessNow !== 16'hFFFF; i++) tick(1);
    chk(brightnessNow, 16'hFFFF);
    test_done();
  end
endmodule : led_dimming_pwm_control_tb
